// ### src/acpm_cfg.svh
`ifndef ACPM_CFG_SVH
`define ACPM_CFG_SVH

// Time base.
`define ACPM_CLK_MHZ 64'd125
`define ACPM_TICK_NS 64'd100000000
`define ACPM_TICK_CYCLES (`ACPM_TICK_NS * `ACPM_CLK_MHZ / 64'd1000)
`define ACPM_TICK_MS 32'd100
`define ACPM_HOUR_MS 32'd3600000

// Pulse-train timing, in milliseconds as specified.
`define ACPM_CYCLE_MS 32'd20000
`define ACPM_START_MS 32'd1000
`define ACPM_INVALID_MS 32'd3500
`define ACPM_FULL_SCALE_MS 32'd5000
`define ACPM_CUR_MIN_MS 32'd500
`define ACPM_CUR_MAX_MS 32'd9000
`define ACPM_MNT_MIN_MS 32'd2000
`define ACPM_MNT_MAX_MS 32'd9000

// Service-hour scaling, in 100 hour units.
`define ACPM_SVC_LOW 14'h00a0
`define ACPM_SVC_HIGH 14'h02d0
`define ACPM_SVC_SHIFT 3
`define ACPM_SVC_MAX 14'h270e
`define ACPM_HOURS_PER_UNIT 7'h63

// Register map (byte offsets) and limits.
`define ACPM_REG_WINDOW 8'h00
`define ACPM_REG_MASK 8'h04
`define ACPM_REG_REF 8'h08
`define ACPM_REG_TERM_A 8'h0c
`define ACPM_REG_TERM_B 8'h10
`define ACPM_REG_RELAY 8'h14
`define ACPM_REG_HOURS 8'h18
`define ACPM_REG_STATUS 8'h1c
`define ACPM_WIN_MAX 4'ha
`define ACPM_WIN_RESET 4'ha
`define ACPM_MASK_MAX 8'hc8
`define ACPM_REF_MAX 13'h1388
`define ACPM_RATED_CURRENT 13'h0064
`define ACPM_CODE_POS 8'h5d
`define ACPM_CODE_NEG 8'hc1
`define ACPM_FUNC_RESET 8'h00
`define ACPM_QUO_LIMIT 7'h5b

`endif

// ### src/acpm_pkg.sv
package acpm_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_MASK, ST_CYCLE} acpm_state_t;
  typedef enum logic [1:0] {MD_DATA, MD_INVALID, MD_NODATA} acpm_mode_t;

endpackage

// ### src/acpm_top.sv
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "acpm_cfg.svh"
// Function
// - Output repeats a 20 s cycle while the drive runs at constant speed.
// - Cycle opens with 1 s high; current averaged over a 0.1-1.0 s window.
// - After reaching constant speed, samples are masked for 0-20 s.
// - Reference current 0-500 A sets the 100 percent point.
// - Low pulse lasts averaged current over reference times 5 s.
// - Current low pulse is clamped to 0.5-9 s at 10 and 180 percent.
// - Service-hours high pulse clamped 2-9 s at 16000 and 72000 hours.
// - No masking and no sampling while accelerating or decelerating.
// - Speed change in start pulse: 3.5 s high then 16.5 s low.
// - A cycle whose start pulse completed always runs to its end.
// - Zero current at cycle end stops output until constant speed returns.
// - Low 20 s no-data cycle on speed change at end of a data or invalid cycle, or restart at end or mask.
// - Only the two open-collector terminals take codes 93 or 193.
// - Power-on time accumulates and is shown in 100 hour units.
module acpm_top
  import acpm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 32'(`ACPM_TICK_CYCLES),
  parameter int unsigned TICKS_PER_HOUR = `ACPM_HOUR_MS / `ACPM_TICK_MS,
  parameter logic [12:0] RATED_CURRENT = `ACPM_RATED_CURRENT
)(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Drive status pins and measured current in 0.1 A units.
  input wire logic const_speed_pin,
  input wire logic restart_pin,
  input wire logic [12:0] out_current,
  // Pulse outputs.
  output logic avg_current_pulse_out,
  output logic term_a_out,
  output logic term_b_out
);

  localparam logic [7:0] CYCLE_T = 8'(`ACPM_CYCLE_MS / `ACPM_TICK_MS);
  localparam logic [7:0] START_T = 8'(`ACPM_START_MS / `ACPM_TICK_MS);
  localparam logic [7:0] INV_T = 8'(`ACPM_INVALID_MS / `ACPM_TICK_MS);
  localparam logic [7:0] SCALE_T = 8'(`ACPM_FULL_SCALE_MS / `ACPM_TICK_MS);
  localparam logic [7:0] CUR_MIN = 8'(`ACPM_CUR_MIN_MS / `ACPM_TICK_MS);
  localparam logic [7:0] CUR_MAX = 8'(`ACPM_CUR_MAX_MS / `ACPM_TICK_MS);
  localparam logic [7:0] MNT_MIN = 8'(`ACPM_MNT_MIN_MS / `ACPM_TICK_MS);
  localparam logic [7:0] MNT_MAX = 8'(`ACPM_MNT_MAX_MS / `ACPM_TICK_MS);

  // Pin synchronisers: bit 0 constant speed, bit 1 restart in progress.
  logic [1:0] pin_in;
  logic [1:0] s1_q, s2_q, s3_q, flt_q;
  logic [1:0] flt_d;
  assign pin_in = {restart_pin, const_speed_pin};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
      flt_q <= 2'h0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
    end
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_flt
    always_comb
    begin
      flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
    end
  end

  logic accel, restart;
  assign accel = !flt_q[0];
  assign restart = flt_q[1];

  // Register file and bus slave.
  logic [3:0] win_q, win_d;
  logic [7:0] mask_t_q, mask_t_d;
  logic [12:0] ref_q, ref_d;
  logic [7:0] func_a_q, func_a_d, func_b_q, func_b_d, relay_q, relay_d;
  logic wr_q, wr_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic svc_clr;
  logic [13:0] svc_q;
  acpm_state_t state_q;
  acpm_mode_t mode_q;
  logic [7:0] cur_t_q, mnt_t_q;
  logic pulse_q;

  always_comb
  begin
    win_d = win_q;
    mask_t_d = mask_t_q;
    ref_d = ref_q;
    func_a_d = func_a_q;
    func_b_d = func_b_q;
    relay_d = relay_q;
    svc_clr = 1'b0;
    wr_d = 1'b0;
    addr_d = addr_q;
    rdata_d = rdata_q;
    if (hsel && hready && htrans[1])
    begin
      wr_d = hwrite;
      addr_d = {haddr[7:2], 2'b00};
      unique case ({haddr[7:2], 2'b00})
        `ACPM_REG_WINDOW: rdata_d = {28'h0, win_q};
        `ACPM_REG_MASK: rdata_d = {24'h0, mask_t_q};
        `ACPM_REG_REF: rdata_d = {19'h0, ref_q};
        `ACPM_REG_TERM_A: rdata_d = {24'h0, func_a_q};
        `ACPM_REG_TERM_B: rdata_d = {24'h0, func_b_q};
        `ACPM_REG_RELAY: rdata_d = {24'h0, relay_q};
        `ACPM_REG_HOURS: rdata_d = {18'h0, svc_q};
        `ACPM_REG_STATUS: rdata_d = {cur_t_q, mnt_t_q, 8'h0, 1'b0,
                                     pulse_q, flt_q, mode_q, state_q};
        default: rdata_d = 32'h0;
      endcase
    end
    if (wr_q)
    begin
      unique case (addr_q)
        `ACPM_REG_WINDOW:
          if (hwdata[3:0] == 4'h0)
            win_d = 4'h1;
          else if (hwdata[3:0] > `ACPM_WIN_MAX)
            win_d = `ACPM_WIN_MAX;
          else
            win_d = hwdata[3:0];
        `ACPM_REG_MASK:
          mask_t_d = (hwdata[7:0] > `ACPM_MASK_MAX) ? `ACPM_MASK_MAX
                                                    : hwdata[7:0];
        `ACPM_REG_REF:
          ref_d = (hwdata[12:0] > `ACPM_REF_MAX) ? `ACPM_REF_MAX
                                                 : hwdata[12:0];
        `ACPM_REG_TERM_A: func_a_d = hwdata[7:0];
        `ACPM_REG_TERM_B: func_b_d = hwdata[7:0];
        `ACPM_REG_RELAY:
          if (hwdata[7:0] != `ACPM_CODE_POS && hwdata[7:0] != `ACPM_CODE_NEG)
            relay_d = hwdata[7:0];
        `ACPM_REG_HOURS: svc_clr = (hwdata == 32'h0);
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      win_q <= `ACPM_WIN_RESET;
      mask_t_q <= 8'h00;
      ref_q <= RATED_CURRENT;
      func_a_q <= `ACPM_FUNC_RESET;
      func_b_q <= `ACPM_FUNC_RESET;
      relay_q <= `ACPM_FUNC_RESET;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h0;
    end
    else
    begin
      win_q <= win_d;
      mask_t_q <= mask_t_d;
      ref_q <= ref_d;
      func_a_q <= func_a_d;
      func_b_q <= func_b_d;
      relay_q <= relay_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
    end
  end

  // Time base and power-on hour counter.
  logic [31:0] pre_q, pre_d, hr_tick_q, hr_tick_d;
  logic [6:0] hr_q, hr_d;
  logic [13:0] svc_d;
  logic tick;
  assign tick = (pre_q == TICK_CYCLES - 1);

  always_comb
  begin
    pre_d = tick ? 32'h0 : pre_q + 32'h1;
    hr_tick_d = hr_tick_q;
    hr_d = hr_q;
    svc_d = svc_q;
    if (tick)
    begin
      hr_tick_d = hr_tick_q + 32'h1;
      if (hr_tick_q == TICKS_PER_HOUR - 1)
      begin
        hr_tick_d = 32'h0;
        hr_d = hr_q + 7'h1;
        if (hr_q == `ACPM_HOURS_PER_UNIT)
        begin
          hr_d = 7'h0;
          if (svc_q < `ACPM_SVC_MAX)
            svc_d = svc_q + 14'h1;
        end
      end
    end
    if (svc_clr)
    begin
      svc_d = 14'h0;
      hr_d = 7'h0;
      hr_tick_d = 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_q <= 32'h0;
      hr_tick_q <= 32'h0;
      hr_q <= 7'h0;
      svc_q <= 14'h0;
    end
    else
    begin
      pre_q <= pre_d;
      hr_tick_q <= hr_tick_d;
      hr_q <= hr_d;
      svc_q <= svc_d;
    end
  end

  // Hours pulse width, linear between the clamps.
  logic [7:0] mnt_w;
  logic [13:0] svc_off;
  assign svc_off = (svc_q - `ACPM_SVC_LOW) >> `ACPM_SVC_SHIFT;
  always_comb
  begin
    if (svc_q < `ACPM_SVC_LOW)
      mnt_w = MNT_MIN;
    else if (svc_q > `ACPM_SVC_HIGH)
      mnt_w = MNT_MAX;
    else
      mnt_w = MNT_MIN + svc_off[7:0];
  end

  // Sequencer, averaging and divider.
  acpm_state_t state_d;
  acpm_mode_t mode_d, new_mode;
  logic [7:0] cyc_q, cyc_d, mcnt_q, mcnt_d, cur_t_d, mnt_t_d;
  logic hold_q, hold_d, div_q, div_d, pulse_d, begin_cyc;
  logic [3:0] nsamp_q, nsamp_d;
  logic [16:0] sum_q, sum_d, den_q, den_d;
  logic [23:0] rem_q, rem_d;
  logic [6:0] quo_q, quo_d;
  logic [8:0] cur_end, mnt_end;

  assign cur_end = {1'b0, START_T} + {1'b0, cur_t_q};
  assign mnt_end = cur_end + {1'b0, mnt_t_q};

  always_comb
  begin
    state_d = state_q;
    mode_d = mode_q;
    cyc_d = cyc_q;
    mcnt_d = mcnt_q;
    hold_d = hold_q;
    nsamp_d = nsamp_q;
    sum_d = sum_q;
    den_d = den_q;
    rem_d = rem_q;
    quo_d = quo_q;
    div_d = div_q;
    cur_t_d = cur_t_q;
    mnt_t_d = mnt_t_q;
    begin_cyc = 1'b0;
    new_mode = MD_DATA;
    if (accel)
      hold_d = 1'b0;
    // Repeated subtraction starts on the last tick of the start pulse and needs at
    // most 92 clocks, so the shortest low pulse of five ticks covers it only
    // while a tick lasts at least 19 clocks; a zero reference saturates.
    if (div_q)
    begin
      if (rem_q >= {7'h0, den_q} && quo_q < `ACPM_QUO_LIMIT)
      begin
        rem_d = rem_q - {7'h0, den_q};
        quo_d = quo_q + 7'h1;
      end
      else
      begin
        div_d = 1'b0;
        if ({1'b0, quo_q} < CUR_MIN)
          cur_t_d = CUR_MIN;
        else if ({1'b0, quo_q} > CUR_MAX)
          cur_t_d = CUR_MAX;
        else
          cur_t_d = {1'b0, quo_q};
      end
    end
    unique case (state_q)
      ST_IDLE:
        if (!accel && !hold_q)
        begin
          state_d = ST_MASK;
          mcnt_d = 8'h0;
        end
      ST_MASK:
        if (accel)
          state_d = ST_IDLE;
        else if (tick)
        begin
          if (mcnt_q >= mask_t_q)
          begin
            begin_cyc = 1'b1;
            new_mode = restart ? MD_NODATA : MD_DATA;
          end
          else
            mcnt_d = mcnt_q + 8'h1;
        end
      ST_CYCLE:
      begin
        if (mode_q == MD_DATA && cyc_q < START_T && accel)
          mode_d = MD_INVALID;
        if (tick)
        begin
          if (mode_q == MD_DATA && cyc_q < START_T && !accel &&
              nsamp_q < win_q)
          begin
            sum_d = sum_q + {4'h0, out_current};
            nsamp_d = nsamp_q + 4'h1;
          end
          if (mode_q == MD_DATA && !accel && cyc_q == START_T - 8'h1)
          begin
            rem_d = 24'(sum_d * SCALE_T);
            den_d = 17'(nsamp_d * ref_q);
            quo_d = 7'h0;
            div_d = 1'b1;
          end
          // The cycle always runs out once started, whatever the speed.
          if (cyc_q == CYCLE_T - 8'h1)
          begin
            if (accel && mode_q == MD_NODATA)
              state_d = ST_IDLE;
            else if (accel || restart)
            begin
              begin_cyc = 1'b1;
              new_mode = MD_NODATA;
            end
            else if (out_current == 13'h0)
            begin
              state_d = ST_IDLE;
              hold_d = 1'b1;
            end
            else if (mode_q == MD_NODATA)
            begin
              state_d = ST_MASK;
              mcnt_d = 8'h0;
            end
            else
              begin_cyc = 1'b1;
          end
          else
            cyc_d = cyc_q + 8'h1;
        end
      end
    endcase
    if (begin_cyc)
    begin
      state_d = ST_CYCLE;
      mode_d = new_mode;
      cyc_d = 8'h0;
      sum_d = 17'h0;
      nsamp_d = 4'h0;
      mnt_t_d = mnt_w;
    end
    pulse_d = 1'b0;
    if (state_q == ST_CYCLE)
    begin
      unique case (mode_q)
        MD_DATA: pulse_d = (cyc_q < START_T) ||
                 ({1'b0, cyc_q} >= cur_end && {1'b0, cyc_q} < mnt_end);
        MD_INVALID: pulse_d = (cyc_q < INV_T);
        MD_NODATA: pulse_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= ST_IDLE;
      mode_q <= MD_DATA;
      cyc_q <= 8'h0;
      mcnt_q <= 8'h0;
      hold_q <= 1'b0;
      nsamp_q <= 4'h0;
      sum_q <= 17'h0;
      den_q <= 17'h0;
      rem_q <= 24'h0;
      quo_q <= 7'h0;
      div_q <= 1'b0;
      cur_t_q <= CUR_MIN;
      mnt_t_q <= MNT_MIN;
      pulse_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      mode_q <= mode_d;
      cyc_q <= cyc_d;
      mcnt_q <= mcnt_d;
      hold_q <= hold_d;
      nsamp_q <= nsamp_d;
      sum_q <= sum_d;
      den_q <= den_d;
      rem_q <= rem_d;
      quo_q <= quo_d;
      div_q <= div_d;
      cur_t_q <= cur_t_d;
      mnt_t_q <= mnt_t_d;
      pulse_q <= pulse_d;
    end
  end

  // Terminal routing; an unassigned terminal stays off.
  logic term_a_q, term_b_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      term_a_q <= 1'b0;
      term_b_q <= 1'b0;
    end
    else
    begin
      term_a_q <= (func_a_q == `ACPM_CODE_POS) ? pulse_q :
                  (func_a_q == `ACPM_CODE_NEG) ? !pulse_q : 1'b0;
      term_b_q <= (func_b_q == `ACPM_CODE_POS) ? pulse_q :
                  (func_b_q == `ACPM_CODE_NEG) ? !pulse_q : 1'b0;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign avg_current_pulse_out = pulse_q;
  assign term_a_out = term_a_q;
  assign term_b_out = term_b_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_start_phase;
    state_q == ST_CYCLE && mode_q == MD_DATA && cyc_q < START_T;
  endsequence

  a_cycle_bound: assert property (cyc_q < CYCLE_T)
    else $error("cycle counter past cycle end");
  a_start_high: assert property (s_start_phase |=> pulse_q)
    else $error("start pulse not high");
  a_win_limit: assert property ($changed(nsamp_q) && nsamp_q != 4'h0 |->
    nsamp_q <= $past(win_q)) else $error("more samples than window");
  a_mask_abort: assert property (state_q == ST_MASK && accel |=>
    state_q == ST_IDLE) else $error("mask ran during speed change");
  a_invalid_entry: assert property (s_start_phase and accel |=>
    mode_q == MD_INVALID) else $error("speed change not judged invalid");
  a_invalid_low: assert property (state_q == ST_CYCLE &&
    mode_q == MD_INVALID && cyc_q >= INV_T |=> !pulse_q)
    else $error("invalid cycle high after 3.5 s");
  a_cur_clamp: assert property (cur_t_q >= CUR_MIN &&
    cur_t_q <= CUR_MAX) else $error("current pulse out of range");
  a_mnt_clamp: assert property (mnt_t_q >= MNT_MIN &&
    mnt_t_q <= MNT_MAX) else $error("hours pulse out of range");
  a_nodata_low: assert property (state_q == ST_CYCLE &&
    mode_q == MD_NODATA |=> !pulse_q) else $error("no-data cycle high");
  a_hold_idle: assert property (state_q == ST_IDLE && hold_q &&
    !accel |=> state_q == ST_IDLE) else $error("suppressed cycle restarted");
  a_relay_free: assert property (relay_q != `ACPM_CODE_POS &&
    relay_q != `ACPM_CODE_NEG) else $error("signal routed to relay");
  a_neg_logic: assert property (func_a_q == `ACPM_CODE_NEG |=>
    term_a_q == !$past(pulse_q)) else $error("negative logic not inverted");

endmodule // acpm_top

// ### verif/acpm_plc_model.sv
`timescale 1ns/10ps
// Stands in for the controller input that times the monitor pulses.
// Every finished level run is logged as its level and its length in clocks.
module acpm_plc_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Terminal being timed.
  input wire logic pin
);
  logic prev_q;
  int run_q;
  bit lvl_q[$];
  int len_q[$];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q <= 1'b0;
      run_q <= 1;
    end
    else if (pin !== prev_q)
    begin
      lvl_q.push_back(prev_q);
      len_q.push_back(run_q);
      prev_q <= pin;
      run_q <= 1;
    end
    else
      run_q <= run_q + 1;
  end
endmodule // acpm_plc_model

// ### verif/avg_current_pulse_monitor_test.sv
`timescale 1ns/10ps
`include "acpm_cfg.svh"
module avg_current_pulse_monitor_test;
  import acpm_pkg::*;
  localparam int TK = 20;
  logic hclk, hresetn, hsel, hwrite, cs, rs;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [12:0] cur;
  wire hready;
  logic hreadyout, hresp, pout, ta, tb_o;
  int bad_count, samples_checked;

  acpm_top #(.TICK_CYCLES(TK), .TICKS_PER_HOUR(1)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .const_speed_pin(cs), .restart_pin(rs),
    .out_current(cur), .avg_current_pulse_out(pout), .term_a_out(ta),
    .term_b_out(tb_o)
  );
  assign hready = hreadyout;
  acpm_plc_model plc (.clk(hclk), .rst_n(hresetn), .pin(ta));

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task results;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(nm, e, rd);
  endtask

  task mode_chk(input logic [1:0] e);
    ahb(1'b0, `ACPM_REG_STATUS, 32'h0);
    check("mode", e, rd[3:2]);
  endtask

  // Idle means state zero and no logged pulse edge left unread in the model's queue.
  task idle_chk;
    ahb(1'b0, `ACPM_REG_STATUS, 32'h0);
    check("state", 2'h0, rd[1:0]);
    check("edges", 0, plc.len_q.size());
  endtask

  task wait_rise(output int n);
    n = 0;
    while (ta !== 1'b1 && n < 5000)
    begin
      @(posedge hclk);
      n++;
    end
    // One more edge so the model has logged the rise before the clear.
    @(posedge hclk);
    plc.len_q.delete();
    plc.lvl_q.delete();
  endtask

  task seg(input bit l, input int n);
    int i;
    i = 0;
    while (plc.len_q.size() == 0 && i < 9000)
    begin
      @(posedge hclk);
      i++;
    end
    if (plc.len_q.size() == 0)
      check("run length", n, 0);
    else
    begin
      check("run level", l, plc.lvl_q.pop_front());
      check("run length", n, plc.len_q.pop_front());
    end
  endtask

  function int exp_lo(input int c, input int r);
    int t;
    t = c * 50 / r;
    if (t < 5)
      t = 5;
    if (t > 90)
      t = 90;
    return t * TK;
  endfunction

  task t_regs;
    rdchk("window", `ACPM_REG_WINDOW, 32'ha);
    rdchk("mask", `ACPM_REG_MASK, 32'h0);
    rdchk("ref", `ACPM_REG_REF, 32'h64);
    rdchk("unmapped", 8'h40, 32'h0);
    check("response", 32'h2, {hreadyout, hresp});
    ahb(1'b1, `ACPM_REG_WINDOW, 32'h0);
    rdchk("window low", `ACPM_REG_WINDOW, 32'h1);
    ahb(1'b1, `ACPM_REG_WINDOW, 32'hb);
    rdchk("window high", `ACPM_REG_WINDOW, 32'ha);
    ahb(1'b1, `ACPM_REG_TERM_A, 32'h5d);
    ahb(1'b1, `ACPM_REG_TERM_B, 32'hc1);
    ahb(1'b1, `ACPM_REG_RELAY, 32'h5d);
    rdchk("relay", `ACPM_REG_RELAY, 32'h0);
    rdchk("term a", `ACPM_REG_TERM_A, 32'h5d);
  endtask

  task t_mask;
    int n;
    ahb(1'b1, `ACPM_REG_MASK, 32'h32);
    check("term b idle", 1'b1, tb_o);
    cs <= 1'b1;
    repeat (500) @(posedge hclk);
    cs <= 1'b0;
    repeat (1500) @(posedge hclk);
    idle_chk;
    cs <= 1'b1;
    wait_rise(n);
    check("mask delay", 1'b1, n >= 1000 && n <= 1080);
    check("term b", 1'b0, tb_o);
    check("pulse out", 1'b1, pout);
    repeat (100) @(posedge hclk);
    cs <= 1'b0;
    seg(1'b1, 35 * TK);
    repeat (5300) @(posedge hclk);
    mode_chk(2'h2);
    repeat (2800) @(posedge hclk);
    idle_chk;
    ahb(1'b1, `ACPM_REG_MASK, 32'h0);
  endtask

  task t_data;
    int n, i;
    int c[4] = '{150, 50, 2000, 0};
    int r[4] = '{100, 1000, 100, 100};
    cs <= 1'b1;
    wait_rise(n);
    for (i = 0; i < 4; i++)
    begin
      // Values change just after each rise: ahead of the first sample, and
      // after the previous cycle's zero-current test at its end.
      cur <= 13'(c[i]);
      ahb(1'b1, `ACPM_REG_REF, 32'(r[i]));
      seg(1'b1, 10 * TK);
      seg(1'b0, exp_lo(c[i], r[i]));
      seg(1'b1, 20 * TK);
      if (i < 3)
        seg(1'b0, 170 * TK - exp_lo(c[i], r[i]));
    end
    repeat (4000) @(posedge hclk);
    idle_chk;
    cs <= 1'b0;
    repeat (10) @(posedge hclk);
  endtask

  task t_drop;
    int n;
    cur <= 13'h0096;
    cs <= 1'b1;
    wait_rise(n);
    seg(1'b1, 10 * TK);
    cs <= 1'b0;
    seg(1'b0, 75 * TK);
    seg(1'b1, 20 * TK);
    repeat (3900) @(posedge hclk);
    mode_chk(2'h2);
    repeat (2500) @(posedge hclk);
    idle_chk;
  endtask

  task t_hours;
    ahb(1'b1, `ACPM_REG_HOURS, 32'h0);
    repeat (2) @(posedge hclk);
    rdchk("hours clear", `ACPM_REG_HOURS, 32'h0);
    repeat (6100) @(posedge hclk);
    ahb(1'b0, `ACPM_REG_HOURS, 32'h0);
    check("hours units", 1'b1, rd >= 2 && rd <= 3);
  endtask

  task t_restart;
    int n;
    rs <= 1'b1;
    cs <= 1'b1;
    repeat (2000) @(posedge hclk);
    mode_chk(2'h2);
    repeat (4000) @(posedge hclk);
    mode_chk(2'h2);
    check("edges", 0, plc.len_q.size());
    rs <= 1'b0;
    wait_rise(n);
    check("data resumes", 1'b1, n < 5000);
    seg(1'b1, 10 * TK);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cs = 1'b0;
    rs = 1'b0;
    cur = 13'h0;
    bad_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_mask;
    t_data;
    t_drop;
    t_hours;
    t_restart;
    results;
  end

  // The planned sequence needs about 52000 clocks.
  initial
  begin
    repeat (90000) @(posedge hclk);
    bad_count++;
    results;
  end
endmodule // avg_current_pulse_monitor_test
